/* gtu_regs.vh */
// register offsets, field positions, codes and timing constants of the timer unit
`ifndef GTU_REGS_VH
`define GTU_REGS_VH

// ----------------------------------------
// clock and count step
// ----------------------------------------
`define GTU_CLK_MHZ 125
`define GTU_STEP_ONE_NS 200
`define GTU_STEP_TWO_NS 100
`define GTU_STEP_ONE_CYC ((`GTU_STEP_ONE_NS * `GTU_CLK_MHZ + 999) / 1000)
`define GTU_STEP_TWO_CYC ((`GTU_STEP_TWO_NS * `GTU_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GTU_A_CTRL_BASE 8'h00
`define GTU_A_CNT_BASE 8'h20
`define GTU_A_STRIDE 8'h04
`define GTU_A_CAPTURE_RELOAD_REG 8'h34
`define GTU_A_FLAGS 8'h38

// ----------------------------------------
// control fields
// ----------------------------------------
`define GTU_F_MODE 1:0
`define GTU_F_RUN 2
`define GTU_F_PRE 5:3
`define GTU_F_EDGE 7:6
`define GTU_F_GPOL 8
`define GTU_F_DIR 9
`define GTU_F_DIRX 10
`define GTU_F_OUTEN 11
`define GTU_F_FUNC 12:11
`define GTU_F_RLDEN 12
`define GTU_F_TRIG 14:13
`define GTU_F_CLREN 15
`define GTU_EDGE_R 0
`define GTU_EDGE_F 1

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define GTU_MODE_TIMER 2'h0
`define GTU_MODE_GATED 2'h1
`define GTU_MODE_COUNT 2'h2
`define GTU_MODE_CHAIN 2'h3
`define GTU_FUNC_NORM 2'h0
`define GTU_FUNC_CAP 2'h1
`define GTU_FUNC_REL 2'h2
`define GTU_TRIG_PIN 2'h0
`define GTU_TRIG_RISE 2'h1
`define GTU_TRIG_FALL 2'h2
`define GTU_TRIG_ANY 2'h3
`define GTU_CTRL_RST 16'h0000
`define GTU_CNT_RST 16'h0000
`define GTU_CNT_MAX 16'hFFFF

`endif

/* gtu_prescale.v */
// prescaler: base step divider followed by a power-of-two divider
`timescale 1ns/1ps
`default_nettype none
`include "gtu_regs.vh"

module gtu_prescale #(
    parameter BASE = 25
)
(
    input wire i_clock,
    input wire i_rst_n,
    input wire [2:0] i_sel,
    output wire o_tick
);
    reg [4:0] base_cnt;
    reg [6:0] div_cnt;
    wire base_pulse;
    wire [6:0] mask;

    assign base_pulse = (base_cnt == BASE - 1);
    assign mask = ~(7'h7F << i_sel);
    assign o_tick = base_pulse && ((div_cnt & mask) == mask);

    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            base_cnt <= 5'h00;
            div_cnt <= 7'h00;
        end
        else if (base_pulse)
        begin
            base_cnt <= 5'h00;
            div_cnt <= div_cnt + 7'h01;
        end
        else
        begin
            base_cnt <= base_cnt + 5'h01;
        end
    end
endmodule // gtu_prescale

`default_nettype wire

/* gtu_timer.v */
// one 16-bit timer cell: mode select, direction, edge detect, load and wrap
`timescale 1ns/1ps
`default_nettype none
`include "gtu_regs.vh"

module gtu_timer
(
    input wire i_clock,
    input wire i_rst_n,
    input wire [1:0] i_mode,
    input wire i_run,
    input wire i_tick,
    input wire i_chain_tick,
    input wire i_pin,
    input wire [1:0] i_edge_sel,
    input wire i_gate_pol,
    input wire i_dir_sw,
    input wire i_dir_ext_en,
    input wire i_dir_pin,
    input wire i_wr,
    input wire [15:0] i_wr_val,
    input wire i_load,
    input wire [15:0] i_load_val,
    input wire i_wrap_load,
    input wire [15:0] i_wrap_val,
    output reg [15:0] o_count,
    output reg o_wrap,
    output wire o_pin_event
);
    reg pin_q;
    reg step;
    wire down;
    wire wrap;

    assign o_pin_event = (i_edge_sel[`GTU_EDGE_R] & i_pin & ~pin_q)
        | (i_edge_sel[`GTU_EDGE_F] & ~i_pin & pin_q);
    assign down = i_dir_ext_en ? i_dir_pin : i_dir_sw;
    assign wrap = step & (down ? (o_count == `GTU_CNT_RST) : (o_count == `GTU_CNT_MAX));

    always @*
    begin
        case (i_mode)
            `GTU_MODE_TIMER: step = i_tick;
            `GTU_MODE_GATED: step = i_tick & (i_pin == i_gate_pol);
            `GTU_MODE_COUNT: step = o_pin_event;
            `GTU_MODE_CHAIN: step = i_chain_tick;
            default: step = 1'b0;
        endcase
        step = step & i_run;
    end

    // software write beats a hardware load, a load beats a count step
    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_count <= `GTU_CNT_RST;
            o_wrap <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            pin_q <= i_pin;
            o_wrap <= wrap;
            if (i_wr)
                o_count <= i_wr_val;
            else if (i_load)
                o_count <= i_load_val;
            else if (wrap && i_wrap_load)
                o_count <= i_wrap_val;
            else if (step)
                o_count <= down ? o_count - 16'h0001 : o_count + 16'h0001;
        end
    end
endmodule // gtu_timer

`default_nettype wire

/* gtu_unit.v */
// timer unit top: five timer modules, capture/reload logic and AHB-Lite slave
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gtu_regs.vh"

module gtu_unit
(
    input wire i_clock,
    input wire i_rst_n,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire [4:0] i_timer_gate_clock_pin,
    input wire [4:0] i_timer_dir_pin,
    input wire i_capture_input_pin,
    output reg [1:0] o_toggle_output_pin,
    output reg o_core_toggle_pin_b,
    output reg o_compare_unit_clock,
    output reg [5:0] o_request
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg [15:0] ctrl [0:4];
    reg [15:0] capture_reload_reg;
    reg core_toggle_latch_a;
    reg aux_toggle_latch_b;
    reg core_toggle_latch_b;
    reg capture_input_pin_q;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg [31:0] next_rdata;
    integer i;
    integer j;

    wire [15:0] cnt [0:4];
    wire [4:0] wrap;
    wire [4:0] pin_event;
    wire [4:0] tick;
    wire [4:0] chain;
    wire [4:0] run;
    wire [4:0] load;
    wire [4:0] cnt_wr;
    wire [15:0] load_val [0:4];
    wire addr_phase;

    // ----------------------------------------
    // capture and reload decisions
    // ----------------------------------------
    wire [1:0] func_a;
    wire [1:0] func_b;
    wire latch_a_rise;
    wire latch_a_fall;
    wire cap_a;
    wire cap_b;
    wire rel_a;
    wire rel_b;
    wire cap2;
    wire [1:0] cap2_edge;

    assign func_a = ctrl[0][`GTU_F_FUNC];
    assign func_b = ctrl[2][`GTU_F_FUNC];
    // latch turns at the end of the cycle in which the wrap pulse stands
    assign latch_a_rise = wrap[1] & ~core_toggle_latch_a;
    assign latch_a_fall = wrap[1] & core_toggle_latch_a;

    assign cap_a = (func_a == `GTU_FUNC_CAP) & pin_event[0];
    assign cap_b = (func_b == `GTU_FUNC_CAP) & pin_event[2];

    function trig_hit;
        input [1:0] sel;
        input pin_ev;
        input rise;
        input fall;
        begin
            case (sel)
                `GTU_TRIG_PIN: trig_hit = pin_ev;
                `GTU_TRIG_RISE: trig_hit = rise;
                `GTU_TRIG_FALL: trig_hit = fall;
                `GTU_TRIG_ANY: trig_hit = rise | fall;
                default: trig_hit = 1'b0;
            endcase
        end
    endfunction

    assign rel_a = (func_a == `GTU_FUNC_REL)
        & trig_hit(ctrl[0][`GTU_F_TRIG], pin_event[0], latch_a_rise, latch_a_fall);
    assign rel_b = (func_b == `GTU_FUNC_REL)
        & trig_hit(ctrl[2][`GTU_F_TRIG], pin_event[2], latch_a_rise, latch_a_fall);

    // module two capture pin uses its own edge select
    assign cap2_edge = ctrl[3][`GTU_F_TRIG];
    assign cap2 = (cap2_edge[`GTU_EDGE_R] & i_capture_input_pin & ~capture_input_pin_q)
        | (cap2_edge[`GTU_EDGE_F] & ~i_capture_input_pin & capture_input_pin_q);

    // aux_timer_a takes precedence when both reload in the same cycle
    assign load[0] = cap_a;
    assign load[1] = rel_a | rel_b;
    assign load[2] = cap_b;
    assign load[3] = cap2 & ctrl[3][`GTU_F_CLREN];
    assign load[4] = 1'b0;
    assign load_val[0] = cnt[1];
    assign load_val[1] = rel_a ? cnt[0] : cnt[2];
    assign load_val[2] = cnt[1];
    assign load_val[3] = `GTU_CNT_RST;
    assign load_val[4] = `GTU_CNT_RST;

    // ----------------------------------------
    // chaining sources
    // ----------------------------------------
    assign chain[0] = wrap[1];
    assign chain[1] = wrap[2];
    assign chain[2] = wrap[1];
    assign chain[3] = wrap[4];
    assign chain[4] = wrap[3];

    // aux timers used for capture or reload are held still
    assign run[0] = ctrl[0][`GTU_F_RUN] & (func_a == `GTU_FUNC_NORM);
    assign run[1] = ctrl[1][`GTU_F_RUN];
    assign run[2] = ctrl[2][`GTU_F_RUN] & (func_b == `GTU_FUNC_NORM);
    assign run[3] = ctrl[3][`GTU_F_RUN];
    assign run[4] = ctrl[4][`GTU_F_RUN];

    // ----------------------------------------
    // five timer cells with their prescalers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_tmr
            localparam [31:0] CNT_ADDR_W = `GTU_A_CNT_BASE + `GTU_A_STRIDE * g;
            localparam [7:0] CNT_ADDR = CNT_ADDR_W[7:0];
            localparam BASE = (g < 3) ? `GTU_STEP_ONE_CYC : `GTU_STEP_TWO_CYC;

            assign cnt_wr[g] = wr_pend && (wr_addr == CNT_ADDR);

            gtu_prescale #(
                .BASE(BASE)
            )
            u_pre
            (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_sel(ctrl[g][`GTU_F_PRE]),
                .o_tick(tick[g])
            );

            gtu_timer u_tmr
            (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_mode(ctrl[g][`GTU_F_MODE]),
                .i_run(run[g]),
                .i_tick(tick[g]),
                .i_chain_tick(chain[g]),
                .i_pin(i_timer_gate_clock_pin[g]),
                .i_edge_sel(ctrl[g][`GTU_F_EDGE]),
                .i_gate_pol(ctrl[g][`GTU_F_GPOL]),
                .i_dir_sw(ctrl[g][`GTU_F_DIR]),
                .i_dir_ext_en(ctrl[g][`GTU_F_DIRX]),
                .i_dir_pin(i_timer_dir_pin[g]),
                .i_wr(cnt_wr[g]),
                .i_wr_val(i_hwdata[15:0]),
                .i_load(load[g]),
                .i_load_val(load_val[g]),
                .i_wrap_load((g == 4) ? ctrl[4][`GTU_F_RLDEN] : 1'b0),
                .i_wrap_val(capture_reload_reg),
                .o_count(cnt[g]),
                .o_wrap(wrap[g]),
                .o_pin_event(pin_event[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // toggle latches, pins and request flags
    // ----------------------------------------
    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            core_toggle_latch_a <= 1'b0;
            aux_toggle_latch_b <= 1'b0;
            core_toggle_latch_b <= 1'b0;
            o_toggle_output_pin <= 2'h0;
            o_core_toggle_pin_b <= 1'b0;
            o_compare_unit_clock <= 1'b0;
            capture_input_pin_q <= 1'b0;
            capture_reload_reg <= `GTU_CNT_RST;
            o_request <= 6'h00;
        end
        else
        begin
            capture_input_pin_q <= i_capture_input_pin;
            if (wrap[1])
                core_toggle_latch_a <= ~core_toggle_latch_a;
            if (wrap[2])
                aux_toggle_latch_b <= ~aux_toggle_latch_b;
            if (wrap[4])
                core_toggle_latch_b <= ~core_toggle_latch_b;
            o_toggle_output_pin[0] <= ctrl[1][`GTU_F_OUTEN] & core_toggle_latch_a;
            o_toggle_output_pin[1] <= ctrl[2][`GTU_F_OUTEN] & aux_toggle_latch_b;
            o_core_toggle_pin_b <= ctrl[4][`GTU_F_OUTEN] & core_toggle_latch_b;
            o_compare_unit_clock <= wrap[4];
            // a capture edge beats a software write in the same cycle
            if (cap2)
                capture_reload_reg <= cnt[3];
            else if (wr_pend && (wr_addr == `GTU_A_CAPTURE_RELOAD_REG))
                capture_reload_reg <= i_hwdata[15:0];
            // write-one-to-clear, a new event in the clearing cycle survives
            o_request <= ((wr_pend && (wr_addr == `GTU_A_FLAGS))
                ? (o_request & ~i_hwdata[5:0]) : o_request)
                | {cap2, wrap[4], wrap[3], wrap[2] | cap_b, wrap[1], wrap[0] | cap_a};
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    // zero wait states; read data is sampled in the address phase
    assign addr_phase = i_hsel & i_hready & i_htrans[1];

    always @*
    begin
        next_rdata = 32'h00000000;
        for (i = 0; i < 5; i = i + 1)
        begin
            if (i_haddr[7:0] == `GTU_A_CTRL_BASE + `GTU_A_STRIDE * i[7:0])
                next_rdata = {16'h0000, ctrl[i]};
            if (i_haddr[7:0] == `GTU_A_CNT_BASE + `GTU_A_STRIDE * i[7:0])
                next_rdata = {16'h0000, cnt[i]};
        end
        if (i_haddr[7:0] == `GTU_A_CAPTURE_RELOAD_REG)
            next_rdata = {16'h0000, capture_reload_reg};
        if (i_haddr[7:0] == `GTU_A_FLAGS)
            next_rdata = {26'h0000000, o_request};
        if (i_haddr[31:8] != 24'h000000)
            next_rdata = 32'h00000000;
    end

    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            for (j = 0; j < 5; j = j + 1)
                ctrl[j] <= `GTU_CTRL_RST;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend <= addr_phase & i_hwrite & (i_haddr[31:8] == 24'h000000);
            if (addr_phase)
                wr_addr <= i_haddr[7:0];
            if (addr_phase && !i_hwrite)
                o_hrdata <= next_rdata;
            for (j = 0; j < 5; j = j + 1)
            begin
                if (wr_pend && (wr_addr == `GTU_A_CTRL_BASE + `GTU_A_STRIDE * j[7:0]))
                    ctrl[j] <= i_hwdata[15:0];
            end
        end
    end
endmodule // gtu_unit

`default_nettype wire

/* gtu_unit_properties.sv */
// concurrent checks on the timer unit ports
`timescale 1ns/1ps
`default_nettype none
module gtu_unit_properties
(
    input wire i_clock,
    input wire i_rst_n,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] o_hrdata,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire o_compare_unit_clock,
    input wire [5:0] o_request
);
    wire take;
    logic rd_d;
    logic fw_d;
    assign take = i_hsel & i_hready & i_htrans[1];
    // ----------------------------------------
    // bus phase tracking
    // ----------------------------------------
    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            rd_d <= 1'b0;
            fw_d <= 1'b0;
        end
        else
        begin
            rd_d <= take & ~i_hwrite;
            fw_d <= take & i_hwrite & (i_haddr == 32'h00000038);
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_ready;
        o_hreadyout && !o_hresp;
    endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    property p_hold;
        !$stable(o_hrdata) |-> rd_d;
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_unmapped;
        take && !i_hwrite && (i_haddr[31:8] != 24'h000000 || i_haddr[7:0] == 8'h3C)
            |=> o_hrdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_upper;
        o_hrdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("reserved read bits set");
    property p_pulse;
        o_compare_unit_clock |=> !o_compare_unit_clock;
    endproperty
    a_pulse: assert property (p_pulse) else $error("compare clock pulse too long");
    property p_cflag;
        o_compare_unit_clock |-> ##[0:2] o_request[4];
    endproperty
    a_cflag: assert property (p_cflag) else $error("wrap without request flag");
    property p_sticky;
        ($past(o_request) & ~o_request) != 6'h00 |-> $past(fw_d);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
    property p_flag_rise;
        $rose(o_request[4]) |-> $past(o_compare_unit_clock, 1) || $past(o_compare_unit_clock, 2)
            || o_compare_unit_clock;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag without wrap");
endmodule // gtu_unit_properties
bind gtu_unit gtu_unit_properties u_props (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_compare_unit_clock(o_compare_unit_clock),
    .o_request(o_request)
);
`default_nettype wire

/* gtu_pin_model.sv */
// pin-side partner: gate/count, direction and capture pins
`timescale 1ns/1ps
`default_nettype none
module gtu_pin_model
(
    input wire logic i_clock,
    output var logic [4:0] o_gate,
    output var logic [4:0] o_dir,
    output var logic o_cap
);
    initial
    begin
        o_gate = 5'h00;
        o_dir = 5'h00;
        o_cap = 1'b0;
    end
    // three high, three low: slow enough for the level sampler
    task pulse(input int i, input int n);
        begin
            repeat (n)
            begin
                @(posedge i_clock);
                o_gate[i] <= 1'b1;
                repeat (3) @(posedge i_clock);
                o_gate[i] <= 1'b0;
                repeat (3) @(posedge i_clock);
            end
        end
    endtask
    task cap_pulse;
        begin
            @(posedge i_clock);
            o_cap <= 1'b1;
            repeat (3) @(posedge i_clock);
            o_cap <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
    endtask
endmodule // gtu_pin_model
`default_nettype wire

/* tb.sv */
// self-checking testbench of the timer unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("mismatch %s expected %h seen %h", n, e, g); \
        end \
    end
module tb;
    logic clock;
    logic rst_n;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] q;
    wire [31:0] hrdata;
    wire hready;
    wire [4:0] gate;
    wire [4:0] dirp;
    wire cap;
    wire [1:0] tog;
    wire togb;
    wire [5:0] req;
    int err_count;
    int compares;
    gtu_unit uut (
        .i_clock(clock),
        .i_rst_n(rst_n),
        .i_hsel(1'b1),
        .i_haddr(haddr),
        .i_htrans(htrans),
        .i_hwrite(hwrite),
        .i_hsize(3'h2),
        .i_hready(hready),
        .i_hwdata(hwdata),
        .o_hrdata(hrdata),
        .o_hreadyout(hready),
        .o_hresp(),
        .i_timer_gate_clock_pin(gate),
        .i_timer_dir_pin(dirp),
        .i_capture_input_pin(cap),
        .o_toggle_output_pin(tog),
        .o_core_toggle_pin_b(togb),
        .o_compare_unit_clock(),
        .o_request(req)
    );
    gtu_pin_model pm (
        .i_clock(clock),
        .o_gate(gate),
        .o_dir(dirp),
        .o_cap(cap)
    );
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task wait_rdy;
        begin
            @(posedge clock);
            while (hready !== 1'b1)
                @(posedge clock);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        begin
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            wait_rdy;
            htrans <= 2'h0;
            hwdata <= d;
            wait_rdy;
            q = hrdata;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        int i;
        begin
            for (i = 0; i < 16; i++)
            begin
                bus(1'b0, 32'(i * 4), 32'h0);
                `CHK("reset value", 32'h00000000, q)
            end
            bus(1'b1, 32'h00000000, 32'hFFFF0230);
            bus(1'b0, 32'h00000000, 32'h0);
            `CHK("ctrl upper bits", 32'h00000230, q)
            bus(1'b1, 32'h00000000, 32'h0);
            // an alias above the map must not reach ctrl0
            bus(1'b1, 32'h00000100, 32'h00000230);
            bus(1'b0, 32'h00000000, 32'h0);
            `CHK("alias write", 32'h00000000, q)
            $display("test regs done");
        end
    endtask
    task t_count;
        begin
            bus(1'b1, 32'h04, 32'h46);
            pm.pulse(1, 5);
            bus(1'b0, 32'h24, 32'h0);
            `CHK("rise count", 32'h5, q)
            bus(1'b1, 32'h04, 32'hC6);
            pm.pulse(1, 1);
            bus(1'b1, 32'h04, 32'h2C6);
            pm.pulse(1, 1);
            bus(1'b0, 32'h24, 32'h0);
            `CHK("both edges and sw down", 32'h5, q)
            bus(1'b1, 32'h04, 32'h4C6);
            pm.o_dir[1] <= 1'b1;
            pm.pulse(1, 1);
            pm.o_dir[1] <= 1'b0;
            bus(1'b0, 32'h24, 32'h0);
            `CHK("dir pin down", 32'h3, q)
            bus(1'b1, 32'h24, 32'h0);
            $display("test count done");
        end
    endtask
    task t_wrap;
        begin
            bus(1'b1, 32'h34, 32'h5);
            bus(1'b1, 32'h10, 32'h1A46);
            bus(1'b1, 32'h04, 32'hA46);
            bus(1'b1, 32'h0C, 32'h7);
            pm.pulse(4, 1);
            pm.pulse(1, 1);
            repeat (4) @(posedge clock);
            bus(1'b0, 32'h30, 32'h0);
            `CHK("reload from capreg", 32'h5, q)
            `CHK("toggle pin b", 1'b1, togb)
            `CHK("toggle pin a", 2'h1, tog)
            `CHK("wrap flags", 6'h12, req)
            bus(1'b0, 32'h2C, 32'h0);
            `CHK("chained count", 32'h1, q)
            bus(1'b1, 32'h38, 32'h3F);
            repeat (2) @(posedge clock);
            `CHK("flags cleared", 6'h00, req)
            bus(1'b1, 32'h10, 32'h0);
            bus(1'b1, 32'h04, 32'h0);
            bus(1'b1, 32'h0C, 32'h0);
            bus(1'b1, 32'h2C, 32'h0);
            $display("test wrap done");
        end
    endtask
    task t_cap;
        begin
            bus(1'b1, 32'h0C, 32'hA046);
            pm.pulse(3, 4);
            pm.cap_pulse;
            repeat (4) @(posedge clock);
            bus(1'b0, 32'h34, 32'h0);
            `CHK("capture value", 32'h4, q)
            bus(1'b0, 32'h2C, 32'h0);
            `CHK("clear after capture", 32'h0, q)
            `CHK("capture flag", 1'b1, req[5])
            bus(1'b1, 32'h0C, 32'h0);
            $display("test capture done");
        end
    endtask
    task t_aux;
        begin
            bus(1'b1, 32'h24, 32'h0);
            bus(1'b1, 32'h04, 32'h46);
            bus(1'b1, 32'h00, 32'h840);
            pm.pulse(1, 3);
            pm.pulse(0, 1);
            repeat (4) @(posedge clock);
            bus(1'b0, 32'h20, 32'h0);
            `CHK("aux capture", 32'h3, q)
            `CHK("aux capture flag", 1'b1, req[0])
            bus(1'b1, 32'h04, 32'h0);
            bus(1'b1, 32'h20, 32'h77);
            bus(1'b1, 32'h00, 32'h1046);
            pm.pulse(0, 1);
            bus(1'b0, 32'h24, 32'h0);
            `CHK("aux reload", 32'h77, q)
            bus(1'b0, 32'h20, 32'h0);
            `CHK("aux stopped", 32'h77, q)
            bus(1'b1, 32'h00, 32'h0);
            $display("test aux done");
        end
    endtask
    // core latch is left high by the wrap test, so the first wrap is a fall
    task t_pwm;
        begin
            bus(1'b1, 32'h20, 32'h2);
            bus(1'b1, 32'h28, 32'h3);
            bus(1'b1, 32'h24, 32'h0);
            bus(1'b1, 32'h00, 32'h3000);
            bus(1'b1, 32'h08, 32'h5000);
            bus(1'b1, 32'h04, 32'h246);
            pm.pulse(1, 1);
            bus(1'b0, 32'h24, 32'h0);
            `CHK("reload on fall", 32'h3, q)
            pm.pulse(1, 4);
            bus(1'b0, 32'h24, 32'h0);
            `CHK("reload on rise", 32'h2, q)
            bus(1'b1, 32'h04, 32'h0);
            bus(1'b1, 32'h00, 32'h0);
            bus(1'b1, 32'h08, 32'h0);
            $display("test pwm done");
        end
    endtask
    task t_free;
        begin
            bus(1'b1, 32'h24, 32'h0);
            bus(1'b1, 32'h04, 32'h04);
            repeat (250) @(posedge clock);
            bus(1'b1, 32'h04, 32'h0);
            bus(1'b0, 32'h24, 32'h0);
            // prescaler phase is free, so allow one step either way
            `CHK("free step", 1'b1, q >= 32'd9 && q <= 32'd11)
            bus(1'b1, 32'h24, 32'h0);
            bus(1'b1, 32'h04, 32'h105);
            repeat (100) @(posedge clock);
            pm.o_gate[1] <= 1'b1;
            repeat (100) @(posedge clock);
            bus(1'b1, 32'h04, 32'h0);
            pm.o_gate[1] <= 1'b0;
            bus(1'b0, 32'h24, 32'h0);
            `CHK("gated count", 1'b1, q >= 32'd3 && q <= 32'd5)
            $display("test free and gated done");
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d mismatches %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        end_of_test;
    end
    initial
    begin
        rst_n = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        err_count = 0;
        compares = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_regs;
        t_count;
        t_wrap;
        t_cap;
        t_aux;
        t_pwm;
        t_free;
        end_of_test;
    end
endmodule // tb
`default_nettype wire
